/* common/phn_pkg.sv */
// Constants shared by the next-page and interrupt-mask register bank.
// Assumes a 5-bit management register address and 16-bit register data.
package phn_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [ADDR_W-1:0] ADDR_NP_TX = 5'h07;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h11;
   localparam logic [ADDR_W-1:0] ADDR_CFG_10BT = 5'h1C;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-page transmit word layout
   localparam int NP_MORE_BIT = 15;
   localparam int NP_ACK_BIT = 14;
   localparam int NP_MSG_BIT = 13;
   localparam int NP_ACK2_BIT = 12;
   localparam int NP_TOGGLE_BIT = 11;
   localparam int NP_CODE_MSB = 10;
   localparam int NP_CODE_W = 11;
   localparam logic [DATA_W-1:0] NP_RESET = 16'h2001;
   localparam logic [DATA_W-1:0] NP_WR_MASK = 16'hB7FF;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt mask and status layout
   localparam int IRQ_CIM_BIT = 15;
   localparam int IRQ_LINK_BIT = 14;
   localparam int IRQ_DSCR_BIT = 13;
   localparam int IRQ_PEND_BIT = 12;
   localparam int IRQ_LSB = 12;
   localparam int IRQ_N = 4;
   localparam logic [DATA_W-1:0] IRQ_IMPL_MASK = 16'hF000;
   localparam logic [DATA_W-1:0] MASK_RESET = 16'h4000;

   ////////////////////////////////////////////////////////////////////////////////
   // 10BASE-T configuration register
   localparam int CFG_LEGACY_BIT = 0;
   localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CFG_WR_MASK = 16'h0001;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

   // Replace only the bits that software may write
   function automatic logic [DATA_W-1:0] phn_wr_merge(input logic [DATA_W-1:0] old_val,
                                                     input logic [DATA_W-1:0] new_val,
                                                     input logic [DATA_W-1:0] wmask);
      phn_wr_merge = (old_val & ~wmask) | (new_val & wmask);
   endfunction

endpackage

/* hw/phn_np_word.sv */
// Next-page transmit word: writable fields plus acknowledge and toggle.
// Assumes ack_set and page_done are one-cycle pulses on core_clk.
module phn_np_word (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [phn_pkg::DATA_W-1:0] wr_data,
   input wire logic ack_set,
   input wire logic page_done,
   output logic [phn_pkg::DATA_W-1:0] word_r
);
   import phn_pkg::*;

   logic [DATA_W-1:0] word_nxt;

   always_comb begin
      word_nxt = word_r;
      if (wr_en) begin
         word_nxt = phn_wr_merge(word_r, wr_data, NP_WR_MASK);
      end
      // Each sent page flips the toggle and drops the old acknowledge
      if (page_done) begin
         word_nxt[NP_ACK_BIT] = 1'b0;
         word_nxt[NP_TOGGLE_BIT] = ~word_r[NP_TOGGLE_BIT];
      end
      // Set beats the clear from page_done
      if (ack_set) begin
         word_nxt[NP_ACK_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         word_r <= NP_RESET;
      end else begin
         word_r <= word_nxt;
      end
   end

endmodule

/* hw/phn_evt_capture.sv */
// Sticky event flags with a per-bit clear.
// Assumes events are one-cycle pulses on core_clk.
module phn_evt_capture #(
   parameter int N = 4
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [N-1:0] evt,
   input wire logic [N-1:0] clr,
   output logic [N-1:0] stat_r
);
   import phn_pkg::*;

   logic [N-1:0] stat_nxt;

   // An event in the clearing cycle survives
   always_comb begin
      stat_nxt = (stat_r & ~clr) | evt;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stat_r <= '0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

endmodule

/* hw/phn_regs.sv */
// Next-page transmit word, interrupt mask, status and 10BASE-T config bank.
// Assumes all event and auto-negotiation inputs come from core_clk logic.
// Register access: plain strobes, read data one cycle after the read strobe.
//
// The address-and-strobe port was left to the implementer.

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Writable more-pages flag, bit 15, reset 0
// - Legacy mode ignores next-page and mask writes, disables mask
// - Read-only acknowledge, set on consistent partner data
// - Message-page flag bit 13, reset 1
// - Writable second acknowledge bit 12, reset 0
// - Read-only toggle bit 11 keeps exchange synced
// - Writable 11-bit code, reset null message
// - Set mask bit lets event assert interrupt
// - Masked events still recorded in status
// - Mask 15 enables carrier-monitor unstable interrupt
// - Mask 14 link change, reset 1
// - Mask 13 descrambler lock change, reset 0
// - Mask 12 premature end error, reset 0
// - Reading status clears all its bits
module phn_regs (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [phn_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [phn_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [phn_pkg::DATA_W-1:0] reg_rdata,
   input wire logic an_ack_set,
   input wire logic an_page_done,
   output logic [phn_pkg::DATA_W-1:0] np_tx_word,
   input wire logic carrier_integrity_monitor_unstable,
   input wire logic link_up,
   input wire logic dscr_locked,
   input wire logic premature_end,
   output logic legacy_mode,
   output logic irq_n
);
   import phn_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   logic wr_np;
   logic wr_mask;
   logic wr_stat;
   logic wr_cfg;
   logic rd_stat;

   logic [DATA_W-1:0] mask_r;
   logic [DATA_W-1:0] mask_nxt;
   logic [DATA_W-1:0] cfg_r;
   logic [DATA_W-1:0] cfg_nxt;
   logic [DATA_W-1:0] mask_eff;
   logic [DATA_W-1:0] stat_word;
   logic [IRQ_N-1:0] stat_r;
   logic [IRQ_N-1:0] evt;
   logic [IRQ_N-1:0] clr;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic irq_n_r;
   logic irq_n_nxt;
   logic link_prev_r;
   logic dscr_prev_r;
   logic primed_r;
   logic link_prev_nxt;
   logic dscr_prev_nxt;
   logic primed_nxt;
   logic link_chg;
   logic dscr_chg;
   logic legacy;

   assign legacy = cfg_r[CFG_LEGACY_BIT];

   always_comb begin
      wr_np = reg_wr && (reg_addr == ADDR_NP_TX) && !legacy;
      wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK) && !legacy;
      wr_stat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
      wr_cfg = reg_wr && (reg_addr == ADDR_CFG_10BT);
      rd_stat = reg_rd && (reg_addr == ADDR_IRQ_STAT);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-page transmit word
   phn_np_word i_phn_np_word (
      .core_clk(core_clk),
      .resetn(resetn),
      .wr_en(wr_np),
      .wr_data(reg_wdata),
      .ack_set(an_ack_set),
      .page_done(an_page_done),
      .word_r(np_tx_word)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Mask and configuration registers
   always_comb begin
      mask_nxt = mask_r;
      cfg_nxt = cfg_r;
      if (wr_mask) begin
         mask_nxt = phn_wr_merge(mask_r, reg_wdata, IRQ_IMPL_MASK);
      end
      if (wr_cfg) begin
         cfg_nxt = phn_wr_merge(cfg_r, reg_wdata, CFG_WR_MASK);
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mask_r <= MASK_RESET;
         cfg_r <= CFG_RESET;
      end else begin
         mask_r <= mask_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // Stored mask is kept so leaving legacy mode restores it
   always_comb begin
      mask_eff = legacy ? DATA_ZERO : mask_r;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event detection
   // Level changes are only trusted once a previous sample exists
   always_comb begin
      link_prev_nxt = link_up;
      dscr_prev_nxt = dscr_locked;
      primed_nxt = 1'b1;
      link_chg = primed_r && (link_up != link_prev_r);
      dscr_chg = primed_r && (dscr_locked != dscr_prev_r);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         link_prev_r <= 1'b0;
         dscr_prev_r <= 1'b0;
         primed_r <= 1'b0;
      end else begin
         link_prev_r <= link_prev_nxt;
         dscr_prev_r <= dscr_prev_nxt;
         primed_r <= primed_nxt;
      end
   end

   // Status records every event whatever the mask says
   always_comb begin
      evt[IRQ_CIM_BIT-IRQ_LSB] = carrier_integrity_monitor_unstable;
      evt[IRQ_LINK_BIT-IRQ_LSB] = link_chg;
      evt[IRQ_DSCR_BIT-IRQ_LSB] = dscr_chg;
      evt[IRQ_PEND_BIT-IRQ_LSB] = premature_end;
      clr = '0;
      if (rd_stat) begin
         clr = '1;
      end else if (wr_stat) begin
         clr = reg_wdata[DATA_W-1:IRQ_LSB];
      end
   end

   phn_evt_capture #(
      .N(IRQ_N)
   ) i_phn_evt_capture (
      .core_clk(core_clk),
      .resetn(resetn),
      .evt(evt),
      .clr(clr),
      .stat_r(stat_r)
   );

   always_comb begin
      stat_word = {stat_r, {IRQ_LSB{1'b0}}};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data and interrupt pin
   always_comb begin
      rdata_nxt = DATA_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_NP_TX: rdata_nxt = np_tx_word;
            ADDR_IRQ_MASK: rdata_nxt = mask_r;
            ADDR_IRQ_STAT: rdata_nxt = stat_word;
            ADDR_CFG_10BT: rdata_nxt = cfg_r;
            default: rdata_nxt = DATA_ZERO;
         endcase
      end
      irq_n_nxt = ~|(stat_word & mask_eff);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= DATA_ZERO;
         irq_n_r <= 1'b1;
      end else begin
         rdata_r <= rdata_nxt;
         irq_n_r <= irq_n_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq_n = irq_n_r;
   assign legacy_mode = cfg_r[CFG_LEGACY_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_more_pages_wr: assert property (
      (reg_wr && reg_addr == ADDR_NP_TX && !legacy)
      |=> np_tx_word[NP_MORE_BIT] == $past(reg_wdata[NP_MORE_BIT]))
      else $error("more-pages flag did not take write");

   a_legacy_np_hold: assert property (
      (reg_wr && reg_addr == ADDR_NP_TX && legacy)
      |=> (np_tx_word & NP_WR_MASK) == ($past(np_tx_word) & NP_WR_MASK))
      else $error("next-page word changed in legacy mode");

   a_legacy_mask_hold: assert property (
      (reg_wr && reg_addr == ADDR_IRQ_MASK && legacy) |=> mask_r == $past(mask_r))
      else $error("mask changed in legacy mode");

   a_ack_set_seen: assert property (
      an_ack_set |=> np_tx_word[NP_ACK_BIT])
      else $error("acknowledge not set");

   a_ack_set_wins: assert property (
      (an_ack_set && an_page_done) |=> np_tx_word[NP_ACK_BIT])
      else $error("acknowledge lost against page done");

   a_ack_page_clear: assert property (
      (an_page_done && !an_ack_set) |=> !np_tx_word[NP_ACK_BIT])
      else $error("acknowledge kept after page done");

   a_ack_read_only: assert property (
      (reg_wr && !an_ack_set && !an_page_done)
      |=> np_tx_word[NP_ACK_BIT] == $past(np_tx_word[NP_ACK_BIT]))
      else $error("acknowledge changed by write");

   a_msg_ack2_wr: assert property (
      (reg_wr && reg_addr == ADDR_NP_TX && !legacy)
      |=> np_tx_word[NP_MSG_BIT:NP_ACK2_BIT] == $past(reg_wdata[NP_MSG_BIT:NP_ACK2_BIT]))
      else $error("message-page or second acknowledge wrong");

   a_toggle_flip: assert property (
      an_page_done |=> np_tx_word[NP_TOGGLE_BIT] != $past(np_tx_word[NP_TOGGLE_BIT]))
      else $error("toggle did not flip");

   a_toggle_hold: assert property (
      !an_page_done |=> $stable(np_tx_word[NP_TOGGLE_BIT]))
      else $error("toggle moved without a page");

   a_code_wr: assert property (
      (reg_wr && reg_addr == ADDR_NP_TX && !legacy)
      |=> np_tx_word[NP_CODE_MSB:0] == $past(reg_wdata[NP_CODE_MSB:0]))
      else $error("code field did not take write");

   a_irq_assert: assert property (
      ((stat_word & mask_eff) != DATA_ZERO) |=> !irq_n)
      else $error("enabled event did not assert pin");

   a_irq_release: assert property (
      ((stat_word & mask_eff) == DATA_ZERO) |=> irq_n)
      else $error("pin low with nothing enabled pending");

   a_masked_recorded: assert property (
      (premature_end && !mask_r[IRQ_PEND_BIT]) |=> stat_r[IRQ_PEND_BIT-IRQ_LSB] ##1 1'b1)
      else $error("masked event not recorded");

   a_cim_event: assert property (
      (carrier_integrity_monitor_unstable ##1 mask_eff[IRQ_CIM_BIT]) |=> !irq_n)
      else $error("carrier monitor event gave no interrupt");

   a_link_event: assert property (
      (primed_r && $changed(link_up)) |=> stat_r[IRQ_LINK_BIT-IRQ_LSB])
      else $error("link change not recorded");

   a_dscr_event: assert property (
      (primed_r && $changed(dscr_locked)) |=> stat_r[IRQ_DSCR_BIT-IRQ_LSB])
      else $error("descrambler change not recorded");

   a_pend_event: assert property (
      premature_end |=> stat_r[IRQ_PEND_BIT-IRQ_LSB])
      else $error("premature end not recorded");

   a_read_clears: assert property (
      (reg_rd && reg_addr == ADDR_IRQ_STAT && evt == '0) |=> stat_r == '0)
      else $error("status read did not clear");

   a_legacy_irq_off: assert property (
      legacy |=> irq_n)
      else $error("pin asserted in legacy mode");

   a_mask_wr: assert property (
      (reg_wr && reg_addr == ADDR_IRQ_MASK && !legacy)
      |=> mask_r == ($past(reg_wdata) & IRQ_IMPL_MASK))
      else $error("mask did not take write");

   a_stat_sticky: assert property (
      (stat_r[IRQ_PEND_BIT-IRQ_LSB] && !rd_stat && !(wr_stat && reg_wdata[IRQ_PEND_BIT]))
      |=> stat_r[IRQ_PEND_BIT-IRQ_LSB])
      else $error("status bit dropped without a clear");

endmodule

/* tb/phn_lp_model.sv */
// Remote link partner model for the next-page exchange.
// Assumes go is a one-cycle request from the bench on core_clk.
module phn_lp_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic go,
   input wire logic slow,
   output logic an_ack_set,
   output logic an_page_done
);
   timeunit 1ns;
   timeprecision 1ns;

   // Ack first, page done one cycle later, as a partner would
   initial begin
      an_ack_set = 1'b0;
      an_page_done = 1'b0;
      forever begin
         @(posedge core_clk);
         if (go && resetn) begin
            repeat (slow ? 4 : 1) @(posedge core_clk);
            an_ack_set <= 1'b1;
            @(posedge core_clk);
            an_ack_set <= 1'b0;
            an_page_done <= 1'b1;
            @(posedge core_clk);
            an_page_done <= 1'b0;
         end
      end
   end
endmodule

/* tb/phn_regs_bench.sv */
// Self-checking bench for the next-page and interrupt-mask bank.
// Assumes phn_regs, phn_pkg and phn_lp_model are compiled before it.
module phn_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import phn_pkg::*;

   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic carrier_integrity_monitor = 1'b0;
   logic link_up = 1'b0;
   logic dscr = 1'b0;
   logic pe = 1'b0;
   logic go = 1'b0;
   logic slow = 1'b0;
   logic tog = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 5'h00;
   logic [DATA_W-1:0] reg_wdata = 16'h0000;
   logic [DATA_W-1:0] reg_rdata;
   logic [DATA_W-1:0] np_tx_word;
   logic an_ack_set;
   logic an_page_done;
   logic legacy_mode;
   logic irq_n;
   int error_cnt = 0;
   int checked = 0;

   always #25 core_clk = ~core_clk;

   phn_regs i_phn_regs (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .an_ack_set(an_ack_set), .an_page_done(an_page_done), .np_tx_word(np_tx_word),
      .carrier_integrity_monitor_unstable(carrier_integrity_monitor), .link_up(link_up), .dscr_locked(dscr),
      .premature_end(pe), .legacy_mode(legacy_mode), .irq_n(irq_n));

   phn_lp_model i_phn_lp_model (.core_clk(core_clk), .resetn(resetn), .go(go), .slow(slow),
      .an_ack_set(an_ack_set), .an_page_done(an_page_done));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("mismatches %0d of %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [4:0] a, logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask

   // Bit 16 selects irq_n, others a bit of np_tx_word
   task automatic wait_for(int b, logic v);
      logic s;
      for (int k = 0; k < 12; k++) begin
         @(posedge core_clk);
         #1 s = (b == 16) ? irq_n : np_tx_word[b];
         checked++;
         if (s === v)
            return;
      end
      error_cnt++;
      $display("[ERR] wait bit %0d expected %b seen %b", b, v, s);
      wrap_up();
   endtask

   // Event i lands in status bit 12+i
   task automatic fire(int i);
      @(posedge core_clk);
      case (i)
         0: pe <= 1'b1;
         1: dscr <= ~dscr;
         2: link_up <= ~link_up;
         default: carrier_integrity_monitor <= 1'b1;
      endcase
      @(posedge core_clk);
      pe <= 1'b0;
      carrier_integrity_monitor <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(ADDR_NP_TX, 16'h2001);
      chk("np_tx_word", 16'h2001, np_tx_word);
      rd(ADDR_IRQ_MASK, 16'h4000);
      rd(ADDR_IRQ_STAT, 16'h0000);
      rd(ADDR_CFG_10BT, 16'h0000);
      rd(5'h05, 16'h0000);
      chk("irq_n", 16'h0001, {15'h0000, irq_n});
   endtask

   task automatic t_np();
      wr(ADDR_NP_TX, 16'hFFFF);
      rd(ADDR_NP_TX, 16'hB7FF);
      chk("np_tx_word", 16'hB7FF, np_tx_word);
      wr(ADDR_NP_TX, 16'h0000);
      rd(ADDR_NP_TX, 16'h0000);
   endtask

   task automatic t_page(logic s);
      @(posedge core_clk);
      slow <= s;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      wait_for(14, 1'b1);
      wait_for(11, ~tog);
      chk("np ack", 16'h0000, {15'h0000, np_tx_word[14]});
      tog = ~tog;
   endtask

   task automatic t_irq();
      wr(ADDR_IRQ_MASK, 16'hF000);
      for (int i = 0; i < 4; i++) begin
         fire(i);
         wait_for(16, 1'b0);
         rd(ADDR_IRQ_STAT, 16'h1000 << i);
         wait_for(16, 1'b1);
         rd(ADDR_IRQ_STAT, 16'h0000);
      end
   endtask

   task automatic t_mask();
      wr(ADDR_IRQ_MASK, 16'h0000);
      fire(0);
      repeat (4) @(posedge core_clk);
      #1 chk("irq_n", 16'h0001, {15'h0000, irq_n});
      wr(ADDR_IRQ_MASK, 16'h1000);
      wait_for(16, 1'b0);
      wr(ADDR_IRQ_MASK, 16'h0000);
      wait_for(16, 1'b1);
      rd(ADDR_IRQ_STAT, 16'h1000);
      fire(0);
      fire(1);
      wr(ADDR_IRQ_STAT, 16'h1000);
      rd(ADDR_IRQ_STAT, 16'h2000);
   endtask

   // Pending event must stay off the pin until legacy mode ends
   task automatic t_legacy();
      wr(ADDR_IRQ_MASK, 16'hF000);
      wr(ADDR_CFG_10BT, 16'h0001);
      #1 chk("legacy_mode", 16'h0001, {15'h0000, legacy_mode});
      wr(ADDR_NP_TX, 16'hFFFF);
      rd(ADDR_NP_TX, 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h0000);
      rd(ADDR_IRQ_MASK, 16'hF000);
      fire(0);
      repeat (4) @(posedge core_clk);
      #1 chk("irq_n", 16'h0001, {15'h0000, irq_n});
      wr(ADDR_CFG_10BT, 16'h0000);
      wait_for(16, 1'b0);
      rd(ADDR_IRQ_STAT, 16'h1000);
      wait_for(16, 1'b1);
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_np();
      t_page(1'b0);
      t_page(1'b1);
      t_irq();
      t_mask();
      t_legacy();
      wrap_up();
   end
endmodule
